// ==== hdl/phy_event_status_counters.sv ====
// Summary of operation
// - Buffer over/under-run flags fault, ends frame
// - Calibration finished sets reset-complete flag
// - Overlong 10 Mb/s transmit cut, jabber flagged
// - Jabber flag holds until status read
// - No jabber detection at 100 Mb/s
// - Negotiation finished sets negotiation-complete flag
// - Unstable legacy link signalling sets detection fault
// - Detection fault clears after management read
// - Unadvertised parallel-detected technology sets detection fail
// - Negotiating: partner remote-fault bit sets flag
// - Not negotiating: far-end fault sets flag
// - Checked received page sets flag, read clears
// - First page base, later pages next-page
// - Link-good loss increments 16-bit counter
// - Counter read-clears and wraps, never saturates
// - Whole status register clears on read
// - Status shows events behind interrupt request
// - Per-event enable gates onto interrupt
// - Counter MSB rising sets rollover flag
//
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`include "phy_event_regs.svh"

module phy_event_status_counters #(
   parameter int unsigned JABBER_CYCLES = `JABBER_LIMIT_NS / `CLK_PERIOD_NS
)(
   input  wire logic                  hclk,
   input  wire logic                  hresetn,
   input  wire logic                  hsel,
   input  wire phy_event_pkg::word32_t haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire phy_event_pkg::word32_t hwdata,
   input  wire logic                  hready,
   output logic                       hreadyout,
   output phy_event_pkg::word32_t     hrdata,
   output logic                       hresp,
   input  wire logic                  speed_10,
   input  wire logic                  an_enable,
   input  wire logic                  tx_active,
   output logic                       tx_cutoff,
   input  wire logic                  elastic_fault,
   output logic                       frame_terminate,
   input  wire logic                  calib_done,
   input  wire logic                  an_complete,
   input  wire logic                  pd_fault,
   input  wire logic                  pd_fail,
   input  wire logic                  partner_remote_fault,
   input  wire logic                  far_end_fault,
   input  wire logic                  page_valid,
   input  wire logic                  page_check_ok,
   input  wire logic                  an_restart,
   output logic                       page_is_next,
   input  wire logic                  link_good,
   input  wire logic                  bmsr_read,
   input  wire phy_event_pkg::word16_t bad_start_count,
   output logic                       irq_n
);
   import phy_event_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic rise(input logic prev, input logic cur);
      rise = !prev && cur;
   endfunction

   function automatic logic reg_hit(input word32_t addr, input reg_idx_t idx);
      reg_hit = (addr[31:`AHB_HI_LSB] == '0) && (addr[`AHB_IDX_MSB:`AHB_IDX_LSB] == idx);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Bus slave: zero wait states, always OKAY

   logic     ap_take;
   logic     ap_read;
   logic     rd_status;
   logic     rd_loss;
   logic     wr_pend_reg;
   logic     wr_pend_next;
   reg_idx_t wr_idx_reg;
   reg_idx_t wr_idx_next;
   logic     wr_enable;
   word32_t  hrdata_reg;
   word32_t  hrdata_next;
   logic     hit_enable;
   logic     hit_status;
   logic     hit_loss;
   logic     hit_bad_start;

   word16_t  status_reg;
   word16_t  status_next;
   word16_t  enable_reg;
   word16_t  enable_next;
   word16_t  loss_cnt_reg;
   word16_t  loss_cnt_next;

   // One decode per register, shared by the read mux and the side effects
   assign hit_enable    = reg_hit(haddr, `EVT_IDX_ENABLE);
   assign hit_status    = reg_hit(haddr, `EVT_IDX_STATUS);
   assign hit_loss      = reg_hit(haddr, `EVT_IDX_LINK_LOSS);
   assign hit_bad_start = reg_hit(haddr, `EVT_IDX_BAD_START);

   assign ap_take   = hsel && hready && htrans[`AHB_HTRANS_SEQ_BIT];
   assign ap_read   = ap_take && !hwrite;
   // Read side effects act at the address phase, with the data latched there
   assign rd_status = ap_read && hit_status;
   assign rd_loss   = ap_read && hit_loss;
   // Writes land at the data-phase end, once hwdata stands
   assign wr_enable = wr_pend_reg && (wr_idx_reg == `EVT_IDX_ENABLE);

   always_comb
   begin
      wr_pend_next = ap_take && hwrite;
      wr_idx_next  = haddr[`AHB_IDX_MSB:`AHB_IDX_LSB];
      // Writes outside the map are dropped
      if (haddr[31:`AHB_HI_LSB] != '0) wr_pend_next = 1'b0;
      hrdata_next  = '0;
      if (ap_read)
      begin
         if (hit_enable)
         begin
            // Forward a write still in its data phase
            if (wr_enable)
               hrdata_next = {16'h0, hwdata[15:0] & `EVT_IMPL_MASK};
            else
               hrdata_next = {16'h0, enable_reg};
         end
         else if (hit_status)
            hrdata_next = {16'h0, status_reg & `EVT_IMPL_MASK};
         else if (hit_loss)
            hrdata_next = {16'h0, loss_cnt_reg};
         else if (hit_bad_start)
            hrdata_next = {16'h0, bad_start_count};
         else
            hrdata_next = '0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_reg <= 1'b0;
         wr_idx_reg  <= '0;
         hrdata_reg  <= '0;
      end
      else
      begin
         wr_pend_reg <= wr_pend_next;
         wr_idx_reg  <= wr_idx_next;
         hrdata_reg  <= hrdata_next;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp     = `AHB_RESP_OKAY;
   assign hrdata    = hrdata_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Jabber watch

   logic jabber_event;

   // Cut-off is a level, so the transmit path stays gated until the MAC stops
   jabber_timer #(
      .JABBER_CYCLES (JABBER_CYCLES)
   ) u_jabber (
      .hclk         (hclk),
      .hresetn      (hresetn),
      .speed_10     (speed_10),
      .tx_active    (tx_active),
      .jabber_event (jabber_event),
      .tx_cutoff    (tx_cutoff)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Edge history and page tracking

   logic calib_prev_reg;
   logic an_done_prev_reg;
   logic link_prev_reg;
   logic page_seen_reg;
   logic page_seen_next;
   logic page_is_next_reg;
   logic page_is_next_next;
   logic frame_term_reg;
   logic calib_prev_next;
   logic an_done_prev_next;
   logic link_prev_next;
   logic frame_term_next;
   logic page_ok;

   assign page_ok = page_valid && page_check_ok;

   always_comb
   begin
      calib_prev_next   = calib_done;
      an_done_prev_next = an_complete;
      link_prev_next    = link_good;
      // Registered so the frame-end strobe is glitch free
      frame_term_next   = elastic_fault;

      page_seen_next    = page_seen_reg;
      page_is_next_next = page_is_next_reg;
      // Restart wins, so a page in its own cycle is not tracked
      if (an_restart)
      begin
         page_seen_next    = 1'b0;
         page_is_next_next = 1'b0;
      end
      else if (page_ok)
      begin
         page_is_next_next = page_seen_reg;
         page_seen_next    = 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         calib_prev_reg   <= 1'b0;
         an_done_prev_reg <= 1'b0;
         link_prev_reg    <= 1'b0;
         page_seen_reg    <= 1'b0;
         page_is_next_reg <= 1'b0;
         frame_term_reg   <= 1'b0;
      end
      else
      begin
         calib_prev_reg   <= calib_prev_next;
         an_done_prev_reg <= an_done_prev_next;
         link_prev_reg    <= link_prev_next;
         page_seen_reg    <= page_seen_next;
         page_is_next_reg <= page_is_next_next;
         frame_term_reg   <= frame_term_next;
      end
   end

   assign page_is_next    = page_is_next_reg;
   assign frame_terminate = frame_term_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Link loss counter

   logic link_loss;

   assign link_loss = link_prev_reg && !link_good;

   always_comb
   begin
      // A loss in the read cycle is kept, not swallowed by the clear
      if (rd_loss)
         loss_cnt_next = link_loss ? `LINK_LOSS_ONE : `LINK_LOSS_RESET;
      else if (link_loss)
         loss_cnt_next = loss_cnt_reg + `LINK_LOSS_ONE;
      else
         loss_cnt_next = loss_cnt_reg;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         loss_cnt_reg <= `LINK_LOSS_RESET;
      else
         loss_cnt_reg <= loss_cnt_next;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Event status and enables

   word16_t set_vec;
   word16_t clr_vec;

   always_comb
   begin
      set_vec = '0;
      set_vec[`EVT_BIT_LB_FAULT]  = elastic_fault;
      set_vec[`EVT_BIT_CAL_DONE]  = rise(calib_prev_reg, calib_done);
      set_vec[`EVT_BIT_JABBER]    = jabber_event && speed_10;
      set_vec[`EVT_BIT_AN_DONE]   = rise(an_done_prev_reg, an_complete);
      set_vec[`EVT_BIT_PD_FAULT]  = pd_fault;
      set_vec[`EVT_BIT_PD_FAIL]   = pd_fail;
      set_vec[`EVT_BIT_RFAULT]    = (an_enable && partner_remote_fault)
                                  || (!an_enable && far_end_fault);
      set_vec[`EVT_BIT_PAGE]      = page_ok;
      set_vec[`EVT_BIT_LOSS_ROLL] = rise(loss_cnt_reg[`LINK_LOSS_MSB],
                                         loss_cnt_next[`LINK_LOSS_MSB]);
      set_vec = set_vec & `EVT_IMPL_MASK;

      clr_vec = '0;
      // A status read clears all; the basic status read only the jabber copy
      if (rd_status)
         clr_vec = '1;
      else if (bmsr_read)
         clr_vec[`EVT_BIT_JABBER] = 1'b1;

      // Set wins over a clear in the same cycle
      status_next = (status_reg & ~clr_vec) | set_vec;

      // Reserved and unused bits never stick
      enable_next = enable_reg;
      if (wr_enable)
         enable_next = hwdata[15:0] & `EVT_IMPL_MASK;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         status_reg <= `EVT_RESET;
         enable_reg <= `EVT_RESET;
      end
      else
      begin
         status_reg <= status_next;
         enable_reg <= enable_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Interrupt request, active low, registered to keep the pin glitch free

   logic    irq_n_reg;
   logic    irq_n_next;
   word16_t pending;

   always_comb
   begin
      // Flagged and enabled events
      pending    = status_reg & enable_reg;
      irq_n_next = ~|pending;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         irq_n_reg <= 1'b1;
      else
         irq_n_reg <= irq_n_next;
   end

   assign irq_n = irq_n_reg;

endmodule // phy_event_status_counters

// ==== hdl/phy_event_regs.svh ====
`ifndef PHY_EVENT_REGS_SVH
`define PHY_EVENT_REGS_SVH

// Register indices; byte address is four times the index
`define EVT_IDX_ENABLE     8'h10
`define EVT_IDX_STATUS     8'h11
`define EVT_IDX_LINK_LOSS  8'h12
`define EVT_IDX_BAD_START  8'h13

// Status and enable bit positions
`define EVT_BIT_PAGE       1
`define EVT_BIT_RFAULT     2
`define EVT_BIT_PD_FAIL    3
`define EVT_BIT_PD_FAULT   4
`define EVT_BIT_AN_DONE    5
`define EVT_BIT_JABBER     6
`define EVT_BIT_CAL_DONE   7
`define EVT_BIT_LB_FAULT   8
`define EVT_BIT_LOSS_ROLL  11

// Implemented bits of status and enable; bit 0 stays zero
`define EVT_IMPL_MASK      16'h09fe
`define EVT_RESET          16'h0000
`define LINK_LOSS_RESET    16'h0000
`define LINK_LOSS_ONE      16'h0001
`define LINK_LOSS_MSB      15

// Bus field values
`define AHB_HTRANS_SEQ_BIT 1
`define AHB_IDX_LSB        2
`define AHB_IDX_MSB        9
`define AHB_HI_LSB         10
`define AHB_RESP_OKAY      1'h0

// Jabber limit and clock period
`define JABBER_LIMIT_NS    105000000
`define CLK_PERIOD_NS      4

`endif

// ==== hdl/phy_event_pkg.sv ====
package phy_event_pkg;

   typedef logic [15:0] word16_t;
   typedef logic [31:0] word32_t;
   typedef logic [7:0]  reg_idx_t;

   // Gray codes along idle -> timing -> cut off
   typedef enum logic [1:0]
   {
      JAB_IDLE   = 2'h0,
      JAB_TIMING = 2'h1,
      JAB_CUTOFF = 2'h3
   } jab_state_t;

endpackage

// ==== hdl/jabber_timer.sv ====
`timescale 1ns/1ps
`include "phy_event_regs.svh"

module jabber_timer #(
   parameter int unsigned JABBER_CYCLES = `JABBER_LIMIT_NS / `CLK_PERIOD_NS
)(
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic speed_10,
   input  wire logic tx_active,
   output logic      jabber_event,
   output logic      tx_cutoff
);
   import phy_event_pkg::*;

   jab_state_t  state_reg;
   jab_state_t  state_next;
   logic [31:0] count_reg;
   logic [31:0] count_next;
   logic        event_next;

   always_comb
   begin
      state_next = state_reg;
      count_next = count_reg;
      event_next = 1'b0;
      case (state_reg)
         JAB_IDLE:
         begin
            count_next = 32'h0;
            // No jabber watch at 100 Mb/s
            if (tx_active && speed_10) state_next = JAB_TIMING;
         end
         JAB_TIMING:
         begin
            if (!tx_active || !speed_10)
               state_next = JAB_IDLE;
            else if (count_next >= 32'(JABBER_CYCLES - 1))
            begin
               state_next = JAB_CUTOFF;
               event_next = 1'b1;
            end
            else
               count_next = count_reg + 32'h1;
         end
         JAB_CUTOFF:
         begin
            // Cut-off holds until the MAC ends the transmission
            if (!tx_active) state_next = JAB_IDLE;
         end
         default: state_next = JAB_IDLE;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state_reg    <= JAB_IDLE;
         count_reg    <= 32'h0;
         jabber_event <= 1'b0;
      end
      else
      begin
         state_reg    <= state_next;
         count_reg    <= count_next;
         jabber_event <= event_next;
      end
   end

   assign tx_cutoff = (state_reg == JAB_CUTOFF);

endmodule // jabber_timer

// ==== tb/phy_event_properties.sv ====
`timescale 1ns/1ps
`include "phy_event_regs.svh"
module phy_event_properties (
   input wire logic                   hclk,
   input wire logic                   hresetn,
   input wire logic                   hsel,
   input wire phy_event_pkg::word32_t haddr,
   input wire logic [1:0]             htrans,
   input wire logic                   hwrite,
   input wire logic                   hready,
   input wire logic                   hreadyout,
   input wire phy_event_pkg::word32_t hrdata,
   input wire logic                   hresp,
   input wire logic                   speed_10,
   input wire logic                   tx_active,
   input wire logic                   tx_cutoff,
   input wire logic                   elastic_fault,
   input wire logic                   frame_terminate,
   input wire logic                   page_valid,
   input wire logic                   page_check_ok,
   input wire logic                   an_restart,
   input wire logic                   page_is_next
);
   import phy_event_pkg::*;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic rd_take;
   assign rd_take = hsel && hready && htrans[1] && !hwrite;
   ////////////////////////////////////////
   a_bus_ready: assert property (hreadyout) else $error("wait state seen");
   a_resp_okay: assert property (!hresp) else $error("error response seen");
   a_frame_end: assert property (
      elastic_fault |=> frame_terminate) else $error("frame not ended");
   a_frame_cause: assert property (
      frame_terminate |-> $past(elastic_fault)) else $error("frame ended without fault");
   a_fast_quiet: assert property (
      (!speed_10 && !tx_cutoff) ##1 !speed_10 |-> !tx_cutoff) else $error("cut off at 100 Mb/s");
   a_cut_cause: assert property (
      $rose(tx_cutoff) |-> $past(tx_active) && $past(speed_10)) else $error("cut off with no cause");
   a_cut_release: assert property (
      !tx_active ##1 !tx_active |-> !tx_cutoff) else $error("cut off held when idle");
   a_stat_bits: assert property (
      rd_take && haddr[9:2] == `EVT_IDX_STATUS |=> (hrdata & 32'hfffff601) == 32'h0) else $error("bad status bit");
   a_idle_zero: assert property (
      !rd_take |=> hrdata == 32'h0) else $error("read data without read");
   a_base_page: assert property (
      an_restart ##1 (page_valid && page_check_ok && !an_restart) |=> !page_is_next) else $error("not base");
   a_next_page: assert property (
      page_valid && page_check_ok && !an_restart ##1 page_valid && page_check_ok && !an_restart |=> page_is_next)
      else $error("not next page");
endmodule // phy_event_properties

bind phy_event_status_counters phy_event_properties chk_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
   .hready, .hreadyout, .hrdata, .hresp, .speed_10, .tx_active, .tx_cutoff, .elastic_fault, .frame_terminate,
   .page_valid, .page_check_ok, .an_restart, .page_is_next);

// ==== tb/mgmt_master.sv ====
`timescale 1ns/1ps
module mgmt_master (
   input  wire logic                   hclk,
   output logic                        hsel,
   output phy_event_pkg::word32_t      haddr,
   output logic [1:0]                  htrans,
   output logic                        hwrite,
   output logic [2:0]                  hsize,
   output phy_event_pkg::word32_t      hwdata,
   input  wire logic                   hready,
   input  wire phy_event_pkg::word32_t hrdata
);
   import phy_event_pkg::*;
   logic hung;
   initial {hsel, haddr, htrans, hwrite, hsize, hwdata, hung} = '0;
   ////////////////////////////////////////
   // Sampled at the falling edge, so the value is what the next rising edge sees
   task automatic wait_rdy(output word32_t d);
      int   n;
      logic ok;
      n = 0;
      ok = 1'b0;
      while (!ok && n < 50)
      begin
         @(negedge hclk);
         ok = hready;
         d = hrdata;
         @(posedge hclk);
         n++;
      end
      if (!ok)
         hung = 1'b1;
   endtask
   // Caller enters just after a rising edge
   task automatic xfer(input logic w, input reg_idx_t idx, input word32_t wd, output word32_t rd);
      word32_t junk;
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {22'h0, idx, 2'h0};
      hwrite <= w;
      hsize <= 3'h2;
      wait_rdy(junk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= w ? wd : ~hwdata;
      wait_rdy(rd);
   endtask
endmodule // mgmt_master

// ==== tb/phy_event_status_counters_tb.sv ====
`timescale 1ns/1ps
`include "phy_event_regs.svh"
module phy_event_status_counters_tb;
   import phy_event_pkg::*;
   logic    hclk = 1'b0;
   logic    hresetn, hsel, hwrite, hreadyout, hresp, speed_10, an_enable, tx_active, tx_cutoff;
   logic    elastic_fault, frame_terminate, calib_done, an_complete, pd_fault, pd_fail, irq_n;
   logic    partner_remote_fault, far_end_fault, page_valid, page_check_ok, an_restart, page_is_next;
   logic    link_good, bmsr_read;
   logic [1:0] htrans;
   logic [2:0] hsize;
   word32_t haddr, hwdata, hrdata;
   word16_t bad_start_count;
   int      bad_count, n_checks;
   always #2 hclk = ~hclk;
   // Short limit keeps the jabber run brief
   phy_event_status_counters #(.JABBER_CYCLES(20)) dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .speed_10, .an_enable, .tx_active,
      .tx_cutoff, .elastic_fault, .frame_terminate, .calib_done, .an_complete, .pd_fault, .pd_fail,
      .partner_remote_fault, .far_end_fault, .page_valid, .page_check_ok, .an_restart, .page_is_next,
      .link_good, .bmsr_read, .bad_start_count, .irq_n);
   mgmt_master mst_u (.hclk, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata);
   ////////////////////////////////////////
   task automatic chk(input word32_t got, input word32_t exp);
      n_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic final_report;
      $display("checks=%0d mismatches=%0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic acc(input logic w, input reg_idx_t idx, input word32_t wd, output word32_t rd);
      mst_u.xfer(w, idx, wd, rd);
      if (mst_u.hung)
      begin
         bad_count++;
         final_report;
      end
   endtask
   task automatic rd_chk(input reg_idx_t idx, input word32_t exp);
      word32_t d;
      acc(1'b0, idx, 32'h0, d);
      chk(d, exp);
   endtask
   task automatic wr(input reg_idx_t idx, input word32_t wd);
      word32_t d;
      acc(1'b1, idx, wd, d);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge hclk);
   endtask
   // Looks between edges so the edge's updates have landed
   task automatic pin(ref logic s, input logic exp);
      @(negedge hclk);
      chk({31'h0, s}, {31'h0, exp});
      @(posedge hclk);
   endtask
   task automatic drive(input int k, input logic v);
      case (k)
         0: elastic_fault <= v;
         1: calib_done <= v;
         2: an_complete <= v;
         3: pd_fault <= v;
         4: pd_fail <= v;
         5: partner_remote_fault <= v;
         6: far_end_fault <= v;
         7: page_valid <= v;
         default:
         begin
            page_valid <= v;
            page_check_ok <= v;
         end
      endcase
   endtask
   ////////////////////////////////////////
   task automatic t_regs;
      pin(irq_n, 1'b1);
      rd_chk(`EVT_IDX_ENABLE, 32'h0);
      rd_chk(`EVT_IDX_STATUS, 32'h0);
      rd_chk(`EVT_IDX_LINK_LOSS, 32'h0);
      rd_chk(`EVT_IDX_BAD_START, 32'h5a3c);
      wr(`EVT_IDX_ENABLE, 32'hffffffff);
      rd_chk(`EVT_IDX_ENABLE, {16'h0, `EVT_IMPL_MASK});
      wr(`EVT_IDX_STATUS, 32'hffff);
      rd_chk(`EVT_IDX_STATUS, 32'h0);
      wr(8'h20, 32'h1234);
      rd_chk(8'h20, 32'h0);
      $display("t_regs done");
   endtask
   // Entry 0 runs masked; 7 to 9 must not set anything
   task automatic t_events;
      int         sg[11] = '{0, 1, 2, 3, 4, 5, 6, 5, 6, 7, 8};
      int         bt[11] = '{8, 7, 5, 4, 3, 2, 2, 0, 0, 0, 1};
      logic [10:0] an = 11'b11100111100;
      word32_t    e;
      for (int i = 0; i < 11; i++)
      begin
         e = bt[i] ? 32'h1 << bt[i] : 32'h0;
         an_enable <= an[i];
         wr(`EVT_IDX_ENABLE, i ? e : 32'h0);
         drive(sg[i], 1'b1);
         tick(1);
         drive(sg[i], 1'b0);
         tick(1);
         pin(irq_n, ~|(i ? e : 32'h0));
         rd_chk(`EVT_IDX_STATUS, e);
         pin(irq_n, 1'b1);
         rd_chk(`EVT_IDX_STATUS, 32'h0);
      end
      $display("t_events done");
   endtask
   task automatic t_jabber;
      speed_10 <= 1'b1;
      tx_active <= 1'b1;
      tick(15);
      tx_active <= 1'b0;
      tick(1);
      tx_active <= 1'b1;
      tick(15);
      pin(tx_cutoff, 1'b0);
      tick(8);
      pin(tx_cutoff, 1'b1);
      tx_active <= 1'b0;
      tick(2);
      pin(tx_cutoff, 1'b0);
      rd_chk(`EVT_IDX_STATUS, 32'h40);
      rd_chk(`EVT_IDX_STATUS, 32'h0);
      tx_active <= 1'b1;
      tick(25);
      tx_active <= 1'b0;
      bmsr_read <= 1'b1;
      tick(1);
      bmsr_read <= 1'b0;
      rd_chk(`EVT_IDX_STATUS, 32'h0);
      speed_10 <= 1'b0;
      tx_active <= 1'b1;
      tick(30);
      pin(tx_cutoff, 1'b0);
      tx_active <= 1'b0;
      rd_chk(`EVT_IDX_STATUS, 32'h0);
      $display("t_jabber done");
   endtask
   task automatic t_page;
      an_restart <= 1'b1;
      tick(1);
      an_restart <= 1'b0;
      drive(8, 1'b1);
      tick(1);
      pin(page_is_next, 1'b0);
      drive(8, 1'b0);
      pin(page_is_next, 1'b1);
      rd_chk(`EVT_IDX_STATUS, 32'h2);
      $display("t_page done");
   endtask
   task automatic losses(input int n);
      repeat (n)
      begin
         link_good <= 1'b1;
         tick(1);
         link_good <= 1'b0;
         tick(1);
      end
   endtask
   // Full wrap would need twice the run length, so only the half-way mark is reached
   task automatic t_link;
      losses(3);
      rd_chk(`EVT_IDX_LINK_LOSS, 32'h3);
      rd_chk(`EVT_IDX_LINK_LOSS, 32'h0);
      losses(32768);
      rd_chk(`EVT_IDX_STATUS, 32'h800);
      rd_chk(`EVT_IDX_LINK_LOSS, 32'h8000);
      $display("t_link done");
   endtask
   ////////////////////////////////////////
   initial
   begin
      {hresetn, speed_10, an_enable, tx_active, elastic_fault, calib_done, an_complete, pd_fault, pd_fail,
       partner_remote_fault, far_end_fault, page_valid, page_check_ok, an_restart, link_good, bmsr_read} = '0;
      bad_start_count = 16'h5a3c;
      bad_count = 0;
      n_checks = 0;
      tick(5);
      hresetn <= 1'b1;
      tick(1);
      t_regs;
      t_events;
      t_jabber;
      t_page;
      t_link;
      final_report;
   end
endmodule // phy_event_status_counters_tb
